// file: rtl/limit_switch_fault_handler.sv
// over-current qualification, response, flag and supply-fault output
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns

// Behaviour
// - the two-bit action field resetting to 00 selects ignore (00), open switch (01) or system shutdown (10, 11).
// - an over-current is reported only when it persists, so short surges give no flag, output or action.
// - the limit switch has its own group interrupt whose only source is the switch over-current flag.
// - the switch over-current flag in bit 15 of the status register sets on the rising edge of a qualified fault.
// - reading the status register clears the switch over-current flag.
// - with mask bit 15 of the mask register at 1 the group interrupt is not asserted for a set flag.
// - the active-low supply-fault output goes low when any regulator, converter or the switch has an unmasked fault.
// - the switch fault drives supply-fault low only while fault-mask bit 15 of the fault config register is 0.
module limit_switch_fault_handler
  import limit_switch_pkg::*;
#(
  parameter int PERSIST_CYCLES = PERSIST_CYC,
  parameter int NUM_SUPPLIES   = 8
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // register port
  input  wire logic [ADDR_W-1:0]       regAddr,
  input  wire logic [DATA_W-1:0]       regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [DATA_W-1:0]       regRdata,
  // fault inputs
  input  wire logic                    overcurrentRaw,
  input  wire logic [NUM_SUPPLIES-1:0] supplyFaultIn,
  input  wire logic                    faultPinSelect,
  // responses
  output logic                         switchOpen,
  output logic                         systemShutdown,
  output logic                         overcurrentGroupIrq,
  output logic                         supplyFaultN,
  output logic                         supplyFaultOe
);

  localparam int CNT_W = (PERSIST_CYCLES > 1) ? $clog2(PERSIST_CYCLES + 1) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERSIST_CYCLES - 1);

  //--------------------------------------------------------------------
  // register state
  //--------------------------------------------------------------------
  reg_req_t          req;
  logic [REG_W-1:0]  lsControl_reg;
  logic [REG_W-1:0]  ocMask_reg;
  logic [REG_W-1:0]  faultCfg_reg;
  logic              flag_reg;
  logic              flag_next;
  logic [DATA_W-1:0] rdata_next;
  qual_state_t       qual_reg;
  qual_state_t       qual_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  fault_out_t        out_reg;
  fault_out_t        out_next;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  //--------------------------------------------------------------------
  // decode
  //--------------------------------------------------------------------
  wire logic hitStatus  = hit(req.addr, IDX_OC_STATUS);
  wire logic hitMask    = hit(req.addr, IDX_OC_MASK);
  wire logic hitControl = hit(req.addr, IDX_LS_CONTROL);
  wire logic hitFault   = hit(req.addr, IDX_FAULT_CFG);
  wire logic statusRead = req.rd && hitStatus;

  //--------------------------------------------------------------------
  // persistence qualifier
  //--------------------------------------------------------------------
  wire logic qualified  = (qual_reg == Q_FAULT);
  wire logic qualRise   = (qual_next == Q_FAULT) && (qual_reg != Q_FAULT);

  always_comb begin
    qual_next = qual_reg;
    cnt_next  = cnt_reg;
    case (qual_reg)
      Q_IDLE: begin
        cnt_next = '0;
        if (overcurrentRaw) begin
          if (cnt_reg == CNT_LAST) qual_next = Q_FAULT;
          else begin
            qual_next = Q_COUNT;
            cnt_next  = CNT_W'(1);
          end
        end
      end
      Q_COUNT: begin
        if (!overcurrentRaw) begin
          qual_next = Q_IDLE;
          cnt_next  = '0;
        end else if (cnt_reg == CNT_LAST) begin
          qual_next = Q_FAULT;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      Q_FAULT: begin
        if (!overcurrentRaw) begin
          qual_next = Q_IDLE;
          cnt_next  = '0;
        end
      end
      default: begin
        qual_next = Q_IDLE;
        cnt_next  = '0;
      end
    endcase
  end

  //--------------------------------------------------------------------
  // flag, set wins over read clear
  //--------------------------------------------------------------------
  assign flag_next = qualRise ? 1'b1 : (statusRead ? 1'b0 : flag_reg);

  //--------------------------------------------------------------------
  // responses
  //--------------------------------------------------------------------
  oc_action_t action;
  assign action = oc_action_t'(lsControl_reg[ACT_HI:ACT_LO]);

  wire logic nextQual   = (qual_next == Q_FAULT);
  wire logic switchFlt  = nextQual && !faultCfg_reg[FAULTMASK_BIT];
  wire logic anyFault   = (|supplyFaultIn) || switchFlt;

  always_comb begin
    out_next.switchOpen          = 1'b0;
    out_next.systemShutdown      = 1'b0;
    case (action)
      ACT_IGNORE: ;
      ACT_OPEN:     out_next.switchOpen     = nextQual || out_reg.switchOpen;
      ACT_SHUTDN_A,
      ACT_SHUTDN_B: out_next.systemShutdown = nextQual || out_reg.systemShutdown;
      default: ;
    endcase
    out_next.overcurrentGroupIrq = flag_next && !ocMask_reg[MASK_BIT];
    out_next.supplyFaultN        = !anyFault;
  end

  //--------------------------------------------------------------------
  // read data
  //--------------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (req.rd) begin
      if (hitStatus)       rdata_next[FLAG_BIT] = flag_reg;
      else if (hitMask)    rdata_next[REG_W-1:0] = ocMask_reg;
      else if (hitControl) rdata_next[REG_W-1:0] = lsControl_reg;
      else if (hitFault)   rdata_next[REG_W-1:0] = faultCfg_reg;
    end
  end

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lsControl_reg <= LS_CONTROL_RST;
      ocMask_reg    <= OC_MASK_RST;
      faultCfg_reg  <= FAULT_CFG_RST;
    end else if (req.wr) begin
      if (hitMask)    ocMask_reg    <= req.wdata[REG_W-1:0];
      if (hitControl) lsControl_reg <= req.wdata[REG_W-1:0];
      if (hitFault)   faultCfg_reg  <= req.wdata[REG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      qual_reg <= Q_IDLE;
      cnt_reg  <= '0;
      flag_reg <= 1'b0;
      out_reg  <= '{switchOpen: 1'b0, systemShutdown: 1'b0, overcurrentGroupIrq: 1'b0, supplyFaultN: 1'b1};
      regRdata <= '0;
      supplyFaultOe <= 1'b0;
    end else begin
      qual_reg <= qual_next;
      cnt_reg  <= cnt_next;
      flag_reg <= flag_next;
      out_reg  <= out_next;
      regRdata <= rdata_next;
      supplyFaultOe <= faultPinSelect;
    end
  end

  assign switchOpen          = out_reg.switchOpen;
  assign systemShutdown      = out_reg.systemShutdown;
  assign overcurrentGroupIrq = out_reg.overcurrentGroupIrq;
  assign supplyFaultN        = out_reg.supplyFaultN;

endmodule : limit_switch_fault_handler

// file: rtl/limit_switch_pkg.sv
// constants and carrier types for the limit switch fault handler
package limit_switch_pkg;

  // register word indices, byte address is four times the index
  localparam logic [7:0] IDX_OC_STATUS   = 8'h1D;
  localparam logic [7:0] IDX_OC_MASK     = 8'h25;
  localparam logic [7:0] IDX_LS_CONTROL  = 8'hC7;
  localparam logic [7:0] IDX_FAULT_CFG   = 8'hD7;
  localparam int         ADDR_W          = 10;
  localparam int         DATA_W          = 32;
  localparam int         REG_W           = 16;

  // field positions
  localparam int FLAG_BIT      = 15;
  localparam int MASK_BIT      = 15;
  localparam int FAULTMASK_BIT = 15;
  localparam int ACT_HI        = 15;
  localparam int ACT_LO        = 14;

  // reset values
  localparam logic [15:0] LS_CONTROL_RST = 16'h0003;
  localparam logic [15:0] OC_MASK_RST    = 16'h0000;
  localparam logic [15:0] FAULT_CFG_RST  = 16'h0000;

  // persistence time before a fault counts
  localparam int PERSIST_NS   = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PERSIST_CYC  = (PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ACT_IGNORE   = 2'h0,
    ACT_OPEN     = 2'h1,
    ACT_SHUTDN_A = 2'h2,
    ACT_SHUTDN_B = 2'h3
  } oc_action_t;

  // qualifier states, gray along idle, counting, faulted
  typedef enum logic [1:0] {
    Q_IDLE  = 2'b00,
    Q_COUNT = 2'b01,
    Q_FAULT = 2'b11
  } qual_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic switchOpen;
    logic systemShutdown;
    logic overcurrentGroupIrq;
    logic supplyFaultN;
  } fault_out_t;

endpackage : limit_switch_pkg

// file: sim/limit_switch_fault_handler_properties.sv
// concurrent checks on the limit switch fault handler ports
`timescale 1ns/1ns
module limit_switch_fault_handler_properties
  import limit_switch_pkg::*;
#(
  parameter int PERSIST_CYCLES = 3,
  parameter int NUM_SUPPLIES   = 8
) (
  input wire logic                    sys_clk, rst, regWr, regRd, overcurrentRaw, faultPinSelect,
  input wire logic [ADDR_W-1:0]       regAddr,
  input wire logic [DATA_W-1:0]       regWdata, regRdata,
  input wire logic [NUM_SUPPLIES-1:0] supplyFaultIn,
  input wire logic                    switchOpen, systemShutdown, overcurrentGroupIrq, supplyFaultN, supplyFaultOe
);
  // ----------
  // shadow state
  // ----------
  logic [7:0] runCnt;
  logic [1:0] actReg;
  logic       maskBit;
  logic       fmBit;
  wire        qual = runCnt == 8'(PERSIST_CYCLES);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      runCnt  <= 8'h00;
      actReg  <= 2'h0;
      maskBit <= 1'h0;
      fmBit   <= 1'h0;
    end else begin
      runCnt <= !overcurrentRaw ? 8'h00 : (runCnt > 8'(PERSIST_CYCLES) ? runCnt : runCnt + 8'h01);
      if (regWr && regAddr == 10'h31C) actReg <= regWdata[15:14];
      if (regWr && regAddr == 10'h094) maskBit <= regWdata[15];
      if (regWr && regAddr == 10'h35C) fmBit <= regWdata[15];
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_surge_quiet: assert property ($rose(switchOpen || systemShutdown) |-> runCnt >= 8'(PERSIST_CYCLES))
    else $error("action without persistent over-current");
  a_flag_on_qual: assert property (qual && !maskBit && !$past(maskBit) |-> overcurrentGroupIrq)
    else $error("flag missing after qualification");
  a_irq_source: assert property ($rose(overcurrentGroupIrq) |-> qual || $past(maskBit, 2))
    else $error("group irq without switch flag");
  a_irq_masked: assert property (maskBit && $past(maskBit) |-> !overcurrentGroupIrq)
    else $error("group irq while masked");
  a_open_code: assert property ($rose(switchOpen) |-> actReg == 2'h1)
    else $error("switch opened under wrong code");
  a_shut_code: assert property ($rose(systemShutdown) |-> actReg[1])
    else $error("shutdown under wrong code");
  a_ignore_idle: assert property (actReg == 2'h0 && $past(actReg) == 2'h0 |-> !switchOpen && !systemShutdown)
    else $error("action taken while ignoring");
  a_fault_mask: assert property (fmBit && $past(fmBit) && $past(supplyFaultIn) == '0 |-> supplyFaultN)
    else $error("masked switch fault drives output");
  a_qual_out: assert property (qual && $past(faultPinSelect) && !fmBit && !$past(fmBit) |-> !supplyFaultN)
    else $error("switch fault not on output");
  a_any_fault: assert property (!$past(rst) && $past(faultPinSelect) && $past(supplyFaultIn) != '0 |-> !supplyFaultN)
    else $error("supply fault not on output");
endmodule : limit_switch_fault_handler_properties

bind limit_switch_fault_handler limit_switch_fault_handler_properties #(
  .PERSIST_CYCLES(PERSIST_CYCLES), .NUM_SUPPLIES(NUM_SUPPLIES)) limit_switch_fault_handler_properties_i (
  .sys_clk(sys_clk), .rst(rst), .regWr(regWr), .regRd(regRd), .overcurrentRaw(overcurrentRaw),
  .faultPinSelect(faultPinSelect), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .supplyFaultIn(supplyFaultIn), .switchOpen(switchOpen), .systemShutdown(systemShutdown),
  .overcurrentGroupIrq(overcurrentGroupIrq), .supplyFaultN(supplyFaultN), .supplyFaultOe(supplyFaultOe));

// file: sim/limit_switch_fault_handler_tb_top.sv
// self-checking bench for the limit switch fault handler
`timescale 1ns/1ns
module limit_switch_fault_handler_tb_top;
  import limit_switch_pkg::*;
  logic              sysClk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0, raw = 1'h0, pinSel = 1'h1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0, regRdata, d;
  logic [7:0]        supIn = 8'h00;
  logic              swOpen, shut, irq, sfN, sfOe;
  int                failures = 0, totalChecks = 0;
  logic [9:0]        rowAddr [5] = '{10'h074, 10'h094, 10'h31C, 10'h35C, 10'h3FC};
  logic [15:0]       rowExp [5] = '{16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0000};
  limit_switch_fault_handler #(.PERSIST_CYCLES(3)) limit_switch_fault_handler_i (.sys_clk(sysClk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .overcurrentRaw(raw), .supplyFaultIn(supIn), .faultPinSelect(pinSel), .switchOpen(swOpen),
    .systemShutdown(shut), .overcurrentGroupIrq(irq), .supplyFaultN(sfN), .supplyFaultOe(sfOe));
  initial forever #5 sysClk = ~sysClk;
  // ----------
  // tasks
  // ----------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge sysClk);
    #1;
  endtask : cyc
  task automatic wr(logic [9:0] a, logic [15:0] v);
    @(posedge sysClk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= {16'h0000, v};
    @(posedge sysClk);
    regWr <= 1'h0;
  endtask : wr
  task automatic rd(logic [9:0] a);
    @(posedge sysClk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge sysClk);
    regRd <= 1'h0;
    cyc(0);
    d = regRdata;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (5) @(posedge sysClk);
    rst <= 1'h0;
    wr(10'h3FC, 16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      rd(rowAddr[i]);
      chk("register", {16'h0000, rowExp[i]}, d);
    end
    wr(10'h31C, 16'h4003);
    @(posedge sysClk);
    raw <= 1'h1;
    repeat (2) @(posedge sysClk);
    raw <= 1'h0;
    cyc(4);
    chk("surge", 3'h1, {swOpen, shut, sfN});
    for (int c = 0; c < 4; c++) begin
      wr(10'h31C, {c[1:0], 14'h0003});
      @(posedge sysClk);
      raw <= 1'h1;
      cyc(3);
      chk("action", 4'h2 | {c == 1, c > 1, 2'h0}, {swOpen, shut, irq, sfN});
      rd(10'h074);
      chk("flag", 32'h00008000, d);
      rd(10'h074);
      chk("flag", 32'h00000000, d);
      raw <= 1'h0;
      wr(10'h31C, 16'h0003);
    end
    wr(10'h094, 16'h8000);
    wr(10'h35C, 16'h8000);
    rd(10'h094);
    chk("mask", 32'h00008000, d);
    @(posedge sysClk);
    raw <= 1'h1;
    cyc(4);
    chk("masked", 2'h1, {irq, sfN});
    rd(10'h074);
    chk("flag", 32'h00008000, d);
    raw <= 1'h0;
    supIn <= 8'h01;
    cyc(2);
    chk("supply", 2'h1, {sfN, sfOe});
    supIn <= 8'h00;
    wr(10'h094, 16'h0000);
    // ----------
    // set and read clear in one cycle
    // ----------
    @(posedge sysClk);
    raw <= 1'h1;
    @(posedge sysClk);
    rd(10'h074);
    chk("collide", 32'h00000000, d);
    chk("irq", 1'h1, irq);
    rd(10'h074);
    chk("collide", 32'h00008000, d);
    wr(10'h31C, 16'h4003);
    cyc(1);
    chk("open", 1'h1, swOpen);
    // ----------
    // reset in mid-run
    // ----------
    rst <= 1'h1;
    raw <= 1'h0;
    cyc(2);
    chk("reset", 5'h02, {swOpen, shut, irq, sfN, sfOe});
    rst <= 1'h0;
    rd(10'h31C);
    chk("reset ctl", 32'h00000003, d);
    rd(10'h35C);
    chk("reset cfg", 32'h00000000, d);
    end_of_test();
  end
  initial begin
    repeat (2000) @(posedge sysClk);
    failures++;
    end_of_test();
  end
endmodule : limit_switch_fault_handler_tb_top
